/* rtl/dsg_bank.sv */
// deep-sleep clock gating bank: run, sleep and deep-sleep gate registers,
// apb slave, bus fault check for gated units, sticky interrupt status
// assumes pwr_state and periph_req come from logic on pclk
`include "dsg_regs.svh"
`timescale 1ns/1ns
module dsg_bank
   import dsg_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] pwr_state,
   input wire logic [11:0] periph_req,
   output logic [11:0] unit_en,
   output logic [11:0] unit_clk,
   output logic periph_fault,
   output logic irq
);

   // gather the twelve gate bits of a register into unit order
   function automatic dsg_units_t dsg_pick(input logic [31:0] r);
      dsg_units_t u;
      u[0] = r[`DSG_B_ASER_A];
      u[1] = r[`DSG_B_ASER_B];
      u[2] = r[`DSG_B_SSER_A];
      u[3] = r[`DSG_B_SSER_B];
      u[4] = r[`DSG_B_TWI_A];
      u[5] = r[`DSG_B_TWI_B];
      u[6] = r[`DSG_B_GPC_A];
      u[7] = r[`DSG_B_GPC_B];
      u[8] = r[`DSG_B_GPC_C];
      u[9] = r[`DSG_B_GPC_D];
      u[10] = r[`DSG_B_COMP_A];
      u[11] = r[`DSG_B_COMP_B];
      return u;
   endfunction

   // byte-lane merge, then keep only bits that software may change
   function automatic logic [31:0] dsg_merge(
      input logic [31:0] old,
      input logic [31:0] wd,
      input logic [3:0] strb,
      input logic [31:0] wmask
   );
      logic [31:0] lanes;
      lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old & ~(lanes & wmask)) | (wd & lanes & wmask);
   endfunction

   // lowest set unit, used to record which unit faulted
   function automatic logic [3:0] dsg_first(input dsg_units_t v);
      logic [3:0] idx;
      idx = 4'hF;
      for (int i = 11; i >= 0; i--) begin
         if (v[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction

   logic [31:0] run_cfg_q;
   logic [31:0] run_gate_q;
   logic [31:0] sleep_gate_q;
   logic [31:0] deep_gate_q;
   logic [31:0] status_q;
   logic [31:0] status_d;
   logic [31:0] mask_q;
   logic [3:0] fault_unit_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [11:0] unit_en_q;
   logic periph_fault_q;
   logic irq_q;
   dsg_pwr_t pwr_prev_q;

   // bus decode
   wire setup = psel & ~penable;
   wire access = psel & penable & pready_q;
   wire wr = access & pwrite;
   wire hit_cfg = paddr == `DSG_OFF_RUN_CFG;
   wire hit_run = paddr == `DSG_OFF_RUN_GATE;
   wire hit_sleep = paddr == `DSG_OFF_SLEEP_GATE;
   wire hit_deep = paddr == `DSG_OFF_DEEP_GATE;
   wire hit_stat = paddr == `DSG_OFF_STATUS;
   wire hit_mask = paddr == `DSG_OFF_MASK;
   wire hit_act = paddr == `DSG_OFF_ACTIVE;
   wire hit_fu = paddr == `DSG_OFF_FAULT_UNIT;
   wire hit_any = hit_cfg | hit_run | hit_sleep | hit_deep | hit_stat | hit_mask | hit_act | hit_fu;
   wire wr_cfg = wr & hit_cfg;
   wire wr_run = wr & hit_run;
   wire wr_sleep = wr & hit_sleep;
   wire wr_deep = wr & hit_deep;
   wire wr_stat = wr & hit_stat;
   wire wr_mask = wr & hit_mask;

   // active gate selection by power state
   wire auto_gate = run_cfg_q[`DSG_CFG_AUTO_BIT];
   wire dsg_pwr_t pwr = dsg_pwr_t'(pwr_state);
   wire dsg_units_t run_units = dsg_pick(run_gate_q);
   wire dsg_units_t sleep_units = dsg_pick(sleep_gate_q);
   wire dsg_units_t deep_units = dsg_pick(deep_gate_q);
   wire sel_sleep = auto_gate & (pwr == DSG_PWR_SLEEP);
   wire sel_deep = auto_gate & (pwr == DSG_PWR_DEEP);
   wire dsg_units_t active_units = sel_deep ? deep_units :
                                   sel_sleep ? sleep_units : run_units;

   // events
   wire dsg_units_t bad_req = periph_req & ~unit_en_q;
   wire fault_ev = |bad_req;
   wire deep_ev = (pwr == DSG_PWR_DEEP) & (pwr_prev_q != DSG_PWR_DEEP);
   wire [31:0] ev_bits = (32'(fault_ev) << `DSG_ST_FAULT_BIT) |
                         (32'(deep_ev) << `DSG_ST_DEEP_BIT);
   wire [31:0] clr_bits = wr_stat ? (pwdata & `DSG_IRQ_WMASK) : 32'h0000_0000;

   // set wins over a write-one-to-clear in the same cycle
   always_comb begin
      status_d = (status_q & ~clr_bits) | ev_bits;
   end

   // read mux, sampled in the setup phase so data stand through access
   wire [31:0] rd_mux =
      hit_cfg ? run_cfg_q :
      hit_run ? run_gate_q :
      hit_sleep ? sleep_gate_q :
      hit_deep ? deep_gate_q :
      hit_stat ? status_q :
      hit_mask ? mask_q :
      hit_act ? 32'(active_units) :
      hit_fu ? 32'(fault_unit_q) : 32'h0000_0000;

   // apb handshake: zero wait states, error on unmapped offsets
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup & ~hit_any;
         if (setup & ~pwrite) begin
            prdata_q <= rd_mux;
         end
      end
   end

   // gate registers, only assigned bits take writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_gate_q <= `DSG_GATE_RESET;
         sleep_gate_q <= `DSG_GATE_RESET;
         deep_gate_q <= `DSG_GATE_RESET;
      end else begin
         if (wr_run) begin
            run_gate_q <= dsg_merge(run_gate_q, pwdata, pstrb, `DSG_GATE_WMASK);
         end
         if (wr_sleep) begin
            sleep_gate_q <= dsg_merge(sleep_gate_q, pwdata, pstrb, `DSG_GATE_WMASK);
         end
         if (wr_deep) begin
            deep_gate_q <= dsg_merge(deep_gate_q, pwdata, pstrb, `DSG_GATE_WMASK);
         end
      end
   end

   // configuration, interrupt mask and status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_cfg_q <= `DSG_CFG_RESET;
         mask_q <= `DSG_IRQ_RESET;
         status_q <= `DSG_IRQ_RESET;
         irq_q <= 1'b0;
      end else begin
         if (wr_cfg) begin
            run_cfg_q <= dsg_merge(run_cfg_q, pwdata, pstrb, 32'(1) << `DSG_CFG_AUTO_BIT);
         end
         if (wr_mask) begin
            mask_q <= dsg_merge(mask_q, pwdata, pstrb, `DSG_IRQ_WMASK);
         end
         status_q <= status_d;
         irq_q <= |(status_d & mask_q);
      end
   end

   // enables move only at a rising edge; the latch gate holds them while
   // the clock is high, so no unit sees a shortened pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unit_en_q <= `DSG_EN_RESET;
         pwr_prev_q <= DSG_PWR_RUN;
         periph_fault_q <= 1'b0;
         fault_unit_q <= `DSG_FAULT_NONE;
      end else begin
         unit_en_q <= active_units;
         pwr_prev_q <= pwr;
         periph_fault_q <= fault_ev;
         if (fault_ev) begin
            fault_unit_q <= dsg_first(bad_req);
         end
      end
   end

   // one gate cell per unit
   for (genvar g = 0; g < 12; g++) begin : g_gate
      dsg_clk_gate u_gate (
         .clk(pclk),
         .en(unit_en_q[g]),
         .gclk(unit_clk[g])
      );
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign unit_en = unit_en_q;
   assign periph_fault = periph_fault_q;
   assign irq = irq_q;

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_reset_clear;
      $rose(presetn) |-> unit_en_q == 12'h000 && deep_gate_q == 32'h0000_0000;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("gates not clear after reset");

   property p_deep_apply;
      (pwr == DSG_PWR_DEEP) && auto_gate |=> unit_en_q == $past(deep_units);
   endproperty
   a_deep_apply: assert property (p_deep_apply) else $error("deep-sleep gates not applied");

   property p_run_apply;
      (pwr == DSG_PWR_RUN) |=> unit_en_q == $past(run_units);
   endproperty
   a_run_apply: assert property (p_run_apply) else $error("run gates not applied in run");

   property p_no_auto;
      !auto_gate |=> unit_en_q == $past(run_units);
   endproperty
   a_no_auto: assert property (p_no_auto) else $error("low-power gates used without auto gating");

   property p_fault;
      (|(periph_req & ~unit_en_q)) |=> periph_fault_q && status_q[`DSG_ST_FAULT_BIT];
   endproperty
   a_fault: assert property (p_fault) else $error("gated unit access gave no fault");

   property p_no_fault;
      !(|(periph_req & ~unit_en_q)) |=> !periph_fault_q;
   endproperty
   a_no_fault: assert property (p_no_fault) else $error("fault raised for clocked unit");

   property p_deep_write;
      wr_deep && pstrb == 4'hF |=> deep_gate_q == ($past(pwdata) & `DSG_GATE_WMASK);
   endproperty
   a_deep_write: assert property (p_deep_write) else $error("deep gate write mismatch");

   property p_reserved_read;
      setup && !pwrite && hit_deep |=> (prdata_q & ~`DSG_GATE_WMASK) == 32'h0000_0000 && pready_q;
   endproperty
   a_reserved_read: assert property (p_reserved_read) else $error("reserved gate bits read nonzero");

   property p_en_edge;
      $changed(unit_en_q) |-> unit_en_q == $past(active_units);
   endproperty
   a_en_edge: assert property (p_en_edge) else $error("enable changed off the selected gates");

   property p_run_write;
      wr_run && pstrb == 4'hF |=> run_gate_q == ($past(pwdata) & `DSG_GATE_WMASK);
   endproperty
   a_run_write: assert property (p_run_write) else $error("run gate write mismatch");

   property p_sleep_write;
      wr_sleep && pstrb == 4'hF |=> sleep_gate_q == ($past(pwdata) & `DSG_GATE_WMASK);
   endproperty
   a_sleep_write: assert property (p_sleep_write) else $error("sleep gate write mismatch");

   property p_sleep_apply;
      (pwr == DSG_PWR_SLEEP) && auto_gate |=> unit_en_q == $past(sleep_units);
   endproperty
   a_sleep_apply: assert property (p_sleep_apply) else $error("sleep gates not applied");

   // catches a wrong write mask on any of the three banks
   property p_reserved_hold;
      ((run_gate_q | sleep_gate_q | deep_gate_q) & ~`DSG_GATE_WMASK) == 32'h0000_0000;
   endproperty
   a_reserved_hold: assert property (p_reserved_hold) else $error("reserved gate bits took a value");

   property p_lane_keep;
      wr_deep && !pstrb[3] |=> deep_gate_q[31:24] == $past(deep_gate_q[31:24]);
   endproperty
   a_lane_keep: assert property (p_lane_keep) else $error("comparator gates changed without their lane");

   property p_status_sticky;
      status_q[`DSG_ST_FAULT_BIT] && !(wr_stat && pwdata[`DSG_ST_FAULT_BIT]) |=> status_q[`DSG_ST_FAULT_BIT];
   endproperty
   a_status_sticky: assert property (p_status_sticky) else $error("fault status lost without a clear");

   property p_set_wins;
      fault_ev && wr_stat && pwdata[`DSG_ST_FAULT_BIT] |=> status_q[`DSG_ST_FAULT_BIT];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear won over a new fault");

   property p_irq_quiet;
      !(|status_q) |-> !irq_q;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt high with no status bit");

   property p_slverr;
      setup && !hit_any |=> pslverr_q && pready_q;
   endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped access gave no error");

   // zero wait states: ready never stands two cycles
   property p_pready_pulse;
      pready_q |=> !pready_q;
   endproperty
   a_pready_pulse: assert property (p_pready_pulse) else $error("ready stood longer than one cycle");

   property p_other_write;
      wr && !hit_deep |=> deep_gate_q == $past(deep_gate_q);
   endproperty
   a_other_write: assert property (p_other_write) else $error("deep gates changed by another write");

endmodule

/* rtl/dsg_regs.svh */
// register map and constants of the deep-sleep clock gating bank
// assumes 32-bit apb data, word aligned byte offsets
`ifndef DSG_REGS_SVH
`define DSG_REGS_SVH

`define DSG_OFF_RUN_CFG    12'h000
`define DSG_OFF_RUN_GATE   12'h100
`define DSG_OFF_SLEEP_GATE 12'h110
`define DSG_OFF_DEEP_GATE  12'h124
`define DSG_OFF_STATUS     12'h130
`define DSG_OFF_MASK       12'h134
`define DSG_OFF_ACTIVE     12'h138
`define DSG_OFF_FAULT_UNIT 12'h13C

`define DSG_GATE_RESET     32'h0000_0000
`define DSG_EN_RESET       12'h000
`define DSG_FAULT_NONE     4'hF
`define DSG_GATE_WMASK     32'h030F_5033
`define DSG_CFG_RESET      32'h0000_0000
`define DSG_CFG_AUTO_BIT   0
`define DSG_IRQ_RESET      32'h0000_0000
`define DSG_IRQ_WMASK      32'h0000_0003
`define DSG_ST_FAULT_BIT   0
`define DSG_ST_DEEP_BIT    1

`define DSG_B_COMP_B   25
`define DSG_B_COMP_A   24
`define DSG_B_GPC_D    19
`define DSG_B_GPC_C    18
`define DSG_B_GPC_B    17
`define DSG_B_GPC_A    16
`define DSG_B_TWI_B    14
`define DSG_B_TWI_A    12
`define DSG_B_SSER_B   5
`define DSG_B_SSER_A   4
`define DSG_B_ASER_B   1
`define DSG_B_ASER_A   0

`endif

/* rtl/dsg_pkg.sv */
// types shared by the deep-sleep clock gating bank
// assumes nothing beyond the register header
package dsg_pkg;
   typedef enum logic [1:0] {
      DSG_PWR_RUN   = 2'b00,
      DSG_PWR_SLEEP = 2'b01,
      DSG_PWR_DEEP  = 2'b10
   } dsg_pwr_t;

   typedef logic [11:0] dsg_units_t;
endpackage

/* rtl/dsg_clk_gate.sv */
// glitch-free clock gate for one unit
// assumes en changes only after a rising edge of clk
`timescale 1ns/1ns
module dsg_clk_gate (
   input wire logic clk,
   input wire logic en,
   output logic gclk
);
   logic en_lat;

   // transparent while clk is low, so en is frozen during the high phase
   always_latch begin
      if (!clk) begin
         en_lat <= en;
      end
   end

   assign gclk = clk & en_lat;
endmodule

/* sim/dsg_bank_test.sv */
// self-checking bench for the deep-sleep clock gating bank
// assumes dsg_bank answers apb with zero wait states and no parameters
`include "dsg_regs.svh"
`timescale 1ns/1ns
module dsg_bank_test import dsg_pkg::*;;
   localparam int GBIT[12] = '{0, 1, 4, 5, 12, 14, 16, 17, 18, 19, 24, 25};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, periph_fault, irq, er;
   logic [11:0] paddr, periph_req, unit_en, unit_clk;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [1:0] pwr_state;
   int n_fail, checks;

   dsg_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pwr_state(pwr_state), .periph_req(periph_req), .unit_en(unit_en), .unit_clk(unit_clk),
      .periph_fault(periph_fault), .irq(irq));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // setup, access, then wait for pready with a bound; release only after it
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk({31'h0, pready}, 32'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [31:0] gate_of(input logic [11:0] u);
      gate_of = 32'h0;
      for (int i = 0; i < 12; i++) gate_of[GBIT[i]] = u[i];
   endfunction

   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   task automatic t_reset;
      logic [11:0] offs[4] = '{`DSG_OFF_RUN_CFG, `DSG_OFF_RUN_GATE, `DSG_OFF_SLEEP_GATE, `DSG_OFF_DEEP_GATE};
      chk({20'h0, unit_en}, 32'h0);
      foreach (offs[i]) begin
         apb(1'b0, offs[i], 32'h0);
         chk(rd, 32'h0);
      end
      $display("test reset done");
   endtask

   task automatic t_fields;
      apb(1'b1, `DSG_OFF_DEEP_GATE, 32'hFFFF_FFFF);
      apb(1'b0, `DSG_OFF_DEEP_GATE, 32'h0);
      chk(rd, gate_of(12'hFFF));
      apb(1'b1, `DSG_OFF_DEEP_GATE, ~gate_of(12'hFFF));
      apb(1'b0, `DSG_OFF_DEEP_GATE, 32'h0);
      chk(rd, 32'h0);
      pstrb <= 4'h4;
      apb(1'b1, `DSG_OFF_DEEP_GATE, 32'hFFFF_FFFF);
      pstrb <= 4'hF;
      apb(1'b0, `DSG_OFF_DEEP_GATE, 32'h0);
      chk(rd, 32'h000F_0000);
      $display("test fields done");
   endtask

   task automatic t_deep;
      apb(1'b1, `DSG_OFF_RUN_CFG, 32'h1);
      pwr_state <= DSG_PWR_DEEP;
      for (int i = 0; i < 12; i++) begin
         apb(1'b1, `DSG_OFF_DEEP_GATE, gate_of(12'h1 << i));
         settle(2);
         chk({20'h0, unit_en}, 32'h1 << i);
         @(posedge pclk);
         #2;
         // gated copy is high only in the first half of an enabled cycle
         chk({20'h0, unit_clk}, 32'h1 << i);
      end
      // entering deep-sleep is an event of its own
      apb(1'b0, `DSG_OFF_STATUS, 32'h0);
      chk(rd, 32'h2);
      $display("test deep done");
   endtask

   task automatic t_select;
      logic [1:0] st[5] = '{DSG_PWR_DEEP, DSG_PWR_RUN, DSG_PWR_SLEEP, DSG_PWR_DEEP, DSG_PWR_SLEEP};
      logic au[5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
      logic [11:0] ex[5] = '{12'h001, 12'h001, 12'h004, 12'h040, 12'h001};
      apb(1'b1, `DSG_OFF_RUN_GATE, gate_of(12'h001));
      apb(1'b1, `DSG_OFF_SLEEP_GATE, gate_of(12'h004));
      apb(1'b1, `DSG_OFF_DEEP_GATE, gate_of(12'h040));
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, `DSG_OFF_RUN_CFG, {31'h0, au[i]});
         pwr_state <= st[i];
         settle(3);
         chk({20'h0, unit_en}, {20'h0, ex[i]});
         apb(1'b0, `DSG_OFF_ACTIVE, 32'h0);
         chk(rd, {20'h0, ex[i]});
      end
      $display("test select done");
   endtask

   task automatic t_fault;
      apb(1'b1, `DSG_OFF_RUN_CFG, 32'h1);
      pwr_state <= DSG_PWR_DEEP;
      apb(1'b1, `DSG_OFF_DEEP_GATE, gate_of(12'h001));
      apb(1'b1, `DSG_OFF_MASK, 32'h1);
      apb(1'b1, `DSG_OFF_STATUS, 32'h3);
      repeat (2) @(posedge pclk);
      // enabled unit: no fault, judged in the cycle its flag would stand
      periph_req <= 12'h001;
      @(posedge pclk);
      periph_req <= 12'h000;
      #1;
      chk({31'h0, periph_fault}, 32'h0);
      @(posedge pclk);
      periph_req <= 12'h008;
      @(posedge pclk);
      periph_req <= 12'h000;
      #1;
      chk({31'h0, periph_fault}, 32'h1);
      settle(1);
      chk({31'h0, periph_fault}, 32'h0);
      chk({31'h0, irq}, 32'h1);
      apb(1'b0, `DSG_OFF_FAULT_UNIT, 32'h0);
      chk(rd, 32'h3);
      apb(1'b1, `DSG_OFF_STATUS, 32'h1);
      apb(1'b0, `DSG_OFF_STATUS, 32'h0);
      chk(rd & 32'h1, 32'h0);
      settle(2);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, `DSG_OFF_MASK, 32'h0);
      periph_req <= 12'h800;
      @(posedge pclk);
      periph_req <= 12'h000;
      settle(3);
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, `DSG_OFF_STATUS, 32'h0);
      chk(rd & 32'h1, 32'h1);
      $display("test fault done");
   endtask

   task automatic t_unmapped;
      apb(1'b1, 12'h200, 32'hFFFF_FFFF);
      chk({31'h0, er}, 32'h1);
      apb(1'b0, 12'h200, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b0, `DSG_OFF_DEEP_GATE, 32'h0);
      chk({31'h0, er}, 32'h0);
      chk(rd, gate_of(12'h001));
      apb(1'b1, `DSG_OFF_DEEP_GATE, rd | gate_of(12'h800));
      apb(1'b0, `DSG_OFF_DEEP_GATE, 32'h0);
      chk(rd, gate_of(12'h801));
      $display("test unmapped done");
   endtask

   task automatic stop_test;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // whole run is well under a thousand cycles
   initial begin
      #50000;
      n_fail++;
      stop_test;
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hF;
      pwr_state = DSG_PWR_RUN;
      periph_req = 12'h000;
      n_fail = 0;
      checks = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_fields;
      t_deep;
      t_select;
      t_fault;
      t_unmapped;
      stop_test;
   end
endmodule
